/* lasen_defs.vh */
`ifndef LASEN_DEFS_VH
`define LASEN_DEFS_VH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_HZ           50000000
`define INHIBIT_SEC      5
`define INHIBIT_CYCLES   (`CLK_HZ * `INHIBIT_SEC)
`define INHIBIT_W        28

// ------------------------------------------------------------
// Sequencer states (one-hot)
// ------------------------------------------------------------
`define ST_W             4
`define ST_HELD          4'h1
`define ST_LATCHED       4'h2
`define ST_INHIBIT       4'h4
`define ST_ENABLED       4'h8

`endif

/* sync2.v */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Two-stage synchroniser for one level
// ------------------------------------------------------------
module sync2 (
    // Clock and reset
    input  wire clk_in,
    input  wire rst_in,
    // Level
    input  wire d_in,
    output wire q_out
);
    reg meta_ff;
    reg q_ff;

    // First stage feeds only the second
    always @(posedge clk_in) begin
        if (rst_in) begin
            meta_ff <= 1'b0;
            q_ff    <= 1'b0;
        end else begin
            meta_ff <= d_in;
            q_ff    <= meta_ff;
        end
    end

    assign q_out = q_ff;
endmodule // sync2

`default_nettype wire

/* laser_enable_interlock_sequencer.v */
// Functional notes
// - Reset/start request asserted keeps RF power off and lasing disabled.
// - Request released lights ready at once; keyswitch variants then wait five seconds before enabling.
// - Lasing only while interlock asserted; interlock loss removes RF power.
// - Keyswitch variants latch interlock loss until keyswitch or request toggles.
// - Remote keyswitch: request pulse after power-up starts five-second delay.
// - Shutter-open request required; keyswitch variants delay five seconds after it.
// - OEM variants: interlock not latched, restore re-enables at once.
// - Ready output closed once request released and no latch pending, open (high impedance) while request held or latched.
`timescale 1ns/1ps
`default_nettype none
`include "lasen_defs.vh"

module laser_enable_interlock_sequencer (
    // Clock and reset
    input  wire clk_in,
    input  wire rst_in,
    // Variant strap: high on keyswitch-equipped units
    input  wire keyswitch_variant_in,
    // Isolated control inputs, active high
    input  wire reset_start_req_in,
    input  wire interlock_in,
    input  wire shutter_req_in,
    input  wire keyswitch_on_in,
    // RF driver power and lasing permission
    output wire rf_power_out,
    output wire lase_enable_out,
    // Ready switched output (closed = driven)
    output wire ready_out,
    output wire ready_oe_out,
    // Shutter open status
    output wire shutter_open_indicator_out
);
    // --------------------------------------------------------
    // Input synchronisers
    // --------------------------------------------------------
    wire rst_req_s;
    wire intlk_s;
    wire shut_s;
    wire key_s;
    wire strap_s;

    sync2 u_sync_rst   (.clk_in(clk_in), .rst_in(rst_in), .d_in(reset_start_req_in),   .q_out(rst_req_s));
    sync2 u_sync_intlk (.clk_in(clk_in), .rst_in(rst_in), .d_in(interlock_in),         .q_out(intlk_s));
    sync2 u_sync_shut  (.clk_in(clk_in), .rst_in(rst_in), .d_in(shutter_req_in),       .q_out(shut_s));
    sync2 u_sync_key   (.clk_in(clk_in), .rst_in(rst_in), .d_in(keyswitch_on_in),      .q_out(key_s));
    sync2 u_sync_strap (.clk_in(clk_in), .rst_in(rst_in), .d_in(keyswitch_variant_in), .q_out(strap_s));

    // --------------------------------------------------------
    // State and registers
    // --------------------------------------------------------
    reg [`ST_W-1:0]      state_ff;
    reg [`ST_W-1:0]      nxt_state;
    reg [`INHIBIT_W-1:0] cnt_ff;
    reg [`INHIBIT_W-1:0] nxt_cnt;
    reg [1:0]            warm_ff;
    reg                  key_prev_ff;
    reg                  rf_ff;
    reg                  lase_ff;
    reg                  ready_ff;
    reg                  ready_lvl_ff;
    reg                  shut_ind_ff;

    // Last count of the inhibit; the full-width value is cut on purpose
    localparam [31:0]           INHIBIT_LAST_FULL = `INHIBIT_CYCLES - 1;
    localparam [`INHIBIT_W-1:0] INHIBIT_LAST      = INHIBIT_LAST_FULL[`INHIBIT_W-1:0];

    // --------------------------------------------------------
    // Start-up settling
    // --------------------------------------------------------
    // Synchronisers clear to zero under reset, which reads as a released
    // request; hold the sequencer until real pin levels have arrived
    always @(posedge clk_in) begin
        if (rst_in) begin
            warm_ff <= 2'h0;
        end else begin
            warm_ff <= {warm_ff[0], 1'b1};
        end
    end

    wire sync_valid = warm_ff[1];

    // --------------------------------------------------------
    // Enabling conditions
    // --------------------------------------------------------
    // Strap taken straight from its synchroniser to line up with the inputs;
    // an extra stage would let a keyswitch unit pass as OEM and skip the wait
    wire key_var     = strap_s;
    // Keyswitch off counts as a missing shutter-open request on keyswitch units
    wire key_ok      = ~key_var | key_s;
    // Every condition that must hold before and during lasing
    wire base_ok     = ~rst_req_s & intlk_s & shut_s & key_ok;
    // Interlock loss latches only on keyswitch units; OEM units recover
    wire lock_latch  = ~intlk_s & key_var;
    // Inhibit complete; OEM units skip the wait altogether
    wire inhibit_end = ~key_var | (cnt_ff == INHIBIT_LAST);
    // Keyswitch toggle seen as a rising edge of the synchronised level
    wire key_rise    = key_s & ~key_prev_ff;

    // --------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------
    // Next state and inhibit count; exactly one state code is active
    always @* begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            `ST_HELD: begin
                // Power-up and request held both land here
                nxt_cnt = {`INHIBIT_W{1'b0}};
                if (sync_valid && !rst_req_s) begin
                    nxt_state = `ST_INHIBIT;
                end
            end
            `ST_LATCHED: begin
                // Interlock lost on keyswitch unit: wait for a toggle
                nxt_cnt = {`INHIBIT_W{1'b0}};
                if (rst_req_s) begin
                    // Request pulse counts as the toggle once released
                    nxt_state = `ST_HELD;
                end else if (key_rise && intlk_s) begin
                    nxt_state = `ST_INHIBIT;
                end
            end
            `ST_INHIBIT: begin
                // Count only while every condition holds
                if (rst_req_s) begin
                    nxt_state = `ST_HELD;
                end else if (lock_latch) begin
                    nxt_state = `ST_LATCHED;
                end else if (!base_ok) begin
                    nxt_cnt = {`INHIBIT_W{1'b0}};
                end else if (inhibit_end) begin
                    nxt_state = `ST_ENABLED;
                    nxt_cnt   = {`INHIBIT_W{1'b0}};
                end else begin
                    nxt_cnt = cnt_ff + 1'b1;
                end
            end
            `ST_ENABLED: begin
                // Lasing permitted; any lost condition drops out at once
                nxt_cnt = {`INHIBIT_W{1'b0}};
                if (rst_req_s) begin
                    nxt_state = `ST_HELD;
                end else if (lock_latch) begin
                    nxt_state = `ST_LATCHED;
                end else if (!base_ok) begin
                    // Shutter or key drop; OEM interlock loss unlatched
                    nxt_state = `ST_INHIBIT;
                end
            end
            default: begin
                // Illegal code recovers to the safe state
                nxt_state = `ST_HELD;
                nxt_cnt   = {`INHIBIT_W{1'b0}};
            end
        endcase
    end

    // --------------------------------------------------------
    // Registers
    // --------------------------------------------------------
    // State and inhibit counter
    always @(posedge clk_in) begin
        if (rst_in) begin
            state_ff <= `ST_HELD;
            cnt_ff   <= {`INHIBIT_W{1'b0}};
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // Previous keyswitch level; clears low with its synchroniser, so a key
    // held on through reset shows one rise, while the sequencer is still held
    always @(posedge clk_in) begin
        if (rst_in) begin
            key_prev_ff <= 1'b0;
        end else begin
            key_prev_ff <= key_s;
        end
    end

    // RF power and lasing permission track the next state so they
    // drop on the same edge as the cause, never a cycle late
    always @(posedge clk_in) begin
        if (rst_in) begin
            rf_ff   <= 1'b0;
            lase_ff <= 1'b0;
        end else begin
            rf_ff   <= (nxt_state == `ST_ENABLED) & base_ok;
            lase_ff <= (nxt_state == `ST_ENABLED) & base_ok;
        end
    end

    // Ready switch closed once the request is released and no latch is
    // pending; on keyswitch units it leads the end of the inhibit
    always @(posedge clk_in) begin
        if (rst_in) begin
            ready_ff     <= 1'b0;
            ready_lvl_ff <= 1'b0;
        end else begin
            ready_ff     <= sync_valid & ~rst_req_s & (nxt_state != `ST_LATCHED);
            ready_lvl_ff <= 1'b0;  // Switch only ever pulls to common
        end
    end

    // Shutter open status: request present and, on keyswitch units, key on
    always @(posedge clk_in) begin
        if (rst_in) begin
            shut_ind_ff <= 1'b0;
        end else begin
            shut_ind_ff <= shut_s & key_ok;
        end
    end

    // --------------------------------------------------------
    // Outputs
    // --------------------------------------------------------
    assign rf_power_out               = rf_ff;
    assign lase_enable_out            = lase_ff;
    assign ready_out                  = ready_lvl_ff;  // Switch closes to common
    assign ready_oe_out               = ready_ff;
    assign shutter_open_indicator_out = shut_ind_ff;
endmodule // laser_enable_interlock_sequencer

`default_nettype wire

/* lasen_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------
// Pin checker
// ----------
module lasen_checker (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Strap and control inputs
    input wire logic keyswitch_variant_in,
    input wire logic reset_start_req_in,
    input wire logic interlock_in,
    input wire logic shutter_req_in,
    input wire logic keyswitch_on_in,
    // Outputs watched
    input wire logic rf_power_out,
    input wire logic lase_enable_out,
    input wire logic ready_out,
    input wire logic ready_oe_out,
    input wire logic shutter_open_indicator_out
);
    // All enabling pins present; key only counts on keyswitch units
    wire ok_w = !reset_start_req_in && interlock_in && shutter_req_in && (keyswitch_on_in || !keyswitch_variant_in);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    chk_req_blocks: assert property (
        reset_start_req_in [*4] |-> !rf_power_out && !ready_oe_out) else $error("enabled while request held");
    chk_lock_blocks: assert property (
        !interlock_in [*4] |-> !rf_power_out) else $error("rf on without interlock");
    chk_shut_blocks: assert property (
        !shutter_req_in [*4] |-> !rf_power_out) else $error("rf on without shutter request");
    chk_lase_pair: assert property (
        lase_enable_out == rf_power_out) else $error("lase and rf differ");
    chk_ready_drive: assert property (
        !ready_out) else $error("ready switch drives high");
    chk_ready_on: assert property (
        rf_power_out |-> ready_oe_out) else $error("ready open while enabled");
    chk_oem_fast: assert property (
        (!keyswitch_variant_in && ok_w) [*8] |-> rf_power_out) else $error("oem unit slow to enable");
    // Any keyswitch enable must have had all enabling pins good eight cycles before
    chk_key_wait: assert property (
        keyswitch_variant_in && $rose(rf_power_out) |-> $past(ok_w, 8)) else $error("keyswitch enable too early");
endmodule // lasen_checker
bind laser_enable_interlock_sequencer lasen_checker chk_u (.*);
`default_nettype wire

/* plc_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------
// Machine controller
// ----------
module plc_model (
    // Clock
    input  wire logic clk_in,
    // Isolated control lines towards the laser
    output var logic  reset_start_req_out,
    output var logic  interlock_out,
    output var logic  shutter_req_out,
    output var logic  keyswitch_on_out
);
    // Power-up levels: interlock asserted, request held, shutter and key off
    initial begin
        reset_start_req_out = 1'h1;
        interlock_out = 1'h1;
        shutter_req_out = 1'h0;
        keyswitch_on_out = 1'h0;
    end
    // Lines change on the falling edge only
    task set_lines(input logic req, lock, shut, key);
        @(negedge clk_in);
        {reset_start_req_out, interlock_out, shutter_req_out, keyswitch_on_out} = {req, lock, shut, key};
    endtask
    // Brief request pulse, long enough to pass the synchroniser
    task pulse_req(input int n);
        @(negedge clk_in);
        reset_start_req_out = 1'h1;
        repeat (n) @(negedge clk_in);
        reset_start_req_out = 1'h0;
    endtask
endmodule // plc_model
`default_nettype wire

/* laser_enable_interlock_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module laser_enable_interlock_sequencer_bench;
    logic      clk_in = 1'h0, rst_in = 1'h1, kv = 1'h0;
    wire logic req, lock, shut, key, rf, lase, rdy, rdy_oe, shutter_open_indicator;
    int        miscompares = 0, comparisons = 0;
    // Clock
    always #10 clk_in = ~clk_in;
    plc_model plc_u (.clk_in(clk_in), .reset_start_req_out(req), .interlock_out(lock), .shutter_req_out(shut),
        .keyswitch_on_out(key));
    laser_enable_interlock_sequencer dut_u (.clk_in(clk_in), .rst_in(rst_in), .keyswitch_variant_in(kv),
        .reset_start_req_in(req), .interlock_in(lock), .shutter_req_in(shut), .keyswitch_on_in(key),
        .rf_power_out(rf), .lase_enable_out(lase), .ready_out(rdy), .ready_oe_out(rdy_oe),
        .shutter_open_indicator_out(shutter_open_indicator));
    task complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Bounded wait; running out ends the run
    task wait_rf(input logic exp, input int n);
        for (int i = 0; i < n && rf !== exp; i++) @(negedge clk_in);
        `CHECK(rf, exp)
        if (rf !== exp) complete_run();
    endtask
    task oem_enable;
        plc_u.set_lines(1'h0, 1'h1, 1'h1, 1'h0);
        wait_rf(1'h1, 20);
        `CHECK({lase, rdy, rdy_oe}, 3'h5)
    endtask
    task req_hold;
        plc_u.set_lines(1'h1, 1'h1, 1'h1, 1'h0);
        wait_rf(1'h0, 10);
        repeat (30) @(negedge clk_in);
        `CHECK({rf, rdy_oe}, 2'h0)
        plc_u.set_lines(1'h0, 1'h1, 1'h1, 1'h0);
        wait_rf(1'h1, 20);
    endtask
    task lock_loss;
        plc_u.set_lines(1'h0, 1'h0, 1'h1, 1'h0);
        wait_rf(1'h0, 10);
        plc_u.set_lines(1'h0, 1'h1, 1'h1, 1'h0);
        wait_rf(1'h1, 6);
    endtask
    task shut_drop;
        plc_u.set_lines(1'h0, 1'h1, 1'h0, 1'h0);
        wait_rf(1'h0, 10);
        `CHECK(shutter_open_indicator, 1'h0)
        plc_u.set_lines(1'h0, 1'h1, 1'h1, 1'h0);
        wait_rf(1'h1, 20);
    endtask
    // Full five seconds is out of reach; check the inhibit holds and latches
    task key_unit;
        @(negedge clk_in);
        {rst_in, kv} = 2'h3;
        plc_u.set_lines(1'h0, 1'h1, 1'h1, 1'h1);
        @(negedge clk_in);
        rst_in = 1'h0;
        repeat (2000) begin @(negedge clk_in); `CHECK(rf, 1'h0) end
        `CHECK(rdy_oe, 1'h1)
        plc_u.set_lines(1'h0, 1'h0, 1'h1, 1'h1);
        repeat (10) @(negedge clk_in);
        plc_u.set_lines(1'h0, 1'h1, 1'h1, 1'h1);
        repeat (10) @(negedge clk_in);
        `CHECK({rf, rdy_oe}, 2'h0)
        plc_u.pulse_req(5);
        repeat (10) @(negedge clk_in);
        `CHECK({rf, rdy_oe}, 2'h1)
        plc_u.set_lines(1'h0, 1'h0, 1'h1, 1'h1);
        repeat (10) @(negedge clk_in);
        plc_u.set_lines(1'h0, 1'h1, 1'h1, 1'h0);
        repeat (10) @(negedge clk_in);
        `CHECK({rf, rdy_oe, shutter_open_indicator}, 3'h0)
        plc_u.set_lines(1'h0, 1'h1, 1'h1, 1'h1);
        repeat (10) @(negedge clk_in);
        `CHECK({rf, rdy_oe, shutter_open_indicator}, 3'h3)
    endtask
    // Main sequence
    initial begin
        repeat (2) @(negedge clk_in);
        rst_in = 1'h0;
        repeat (4) begin @(negedge clk_in); `CHECK({rf, rdy_oe}, 2'h0) end
        oem_enable();
        req_hold();
        lock_loss();
        shut_drop();
        key_unit();
        complete_run();
    end
endmodule // laser_enable_interlock_sequencer_bench
`default_nettype wire
